// ===== core/sd_host_defs.svh
// Purpose: addresses, field positions, reset values of the host control block
// Assumes: byte addresses on a 32-bit Avalon-MM bus
// Notes: definitions only
`ifndef SD_HOST_DEFS_SVH
`define SD_HOST_DEFS_SVH
`define MAIN_CTRL_ADDR 32'h5003_0000
`define EVENT_CTRL_ADDR 32'h5003_0004
`define IRQ_CTRL_ADDR 32'h5003_0008
`define FULL_RST_BIT 15
`define IFACE_RST_BIT 14
`define CMD_RST_BIT 13
`define DATA_RST_BIT 12
`define ABORT_BIT 11
`define WSTART_MSB 9
`define WSTART_LSB 8
`define POWER_BIT 7
`define DETECT_POL_BIT 5
`define RD_CRC_BIT 4
`define RSP_CRC_BIT 3
`define WIDE_BUS_BIT 2
`define FAST_TIMING_BIT 1
`define DRIVE_MODE_BIT 0
`define MAIN_CTRL_RESET 32'h0000_0018
`define MAIN_CTRL_MASK 32'h0000_FBBF
`define DETECT_PIN_BIT 31
`define PROTECT_PIN_BIT 30
`define STATUS_LSB 16
`define STATUS_MSB 29
`define GLOBAL_EN_BIT 15
`define PENDING_BIT 31
`define EVENT_EN_RESET 14'h1A37
`define EVENT_VALID 14'h3FF7
`define EVENT_ALWAYS_ON 14'h00C0
`define IRQ_VALID 14'h3F37
`define IRQ_EN_RESET 14'h0000
`define SINGLE_READ_IDX 6
`define DIR_ERROR_IDX 2
`define WSTART_HOLD 2'h2
`define WSTART_FORCE 2'h3
`endif

// ===== core/sd_host_pkg.sv
// Purpose: carrier types of the host control block
// Assumes: engines run on the system clock
// Notes: field order is fixed, engines pack by name
package sd_host_pkg;
  typedef struct packed {
    logic transfer_done_event;
    logic block_done;
    logic bad_crc_token_event;
    logic busy_timeout;
    logic read_done;
    logic single_read_done_event;
    logic read_crc_error;
    logic read_timeout;
    logic response_done;
    logic response_crc_error;
    logic response_timeout;
    logic response_direction_error;
  } engine_events_type;
  typedef struct packed {
    logic command_engine_reset;
    logic data_engine_reset;
    logic abort_transfer;
    logic write_start;
    logic interface_power_on;
    logic read_crc_check_enable;
    logic response_crc_check_enable;
    logic wide_bus_select;
  } engine_ctrl_type;
endpackage

// ===== core/pin_sync.sv
// Purpose: two-flop synchroniser for pad and link levels
// Assumes: inputs are levels from outside the system clock domain
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= '0;
      dout <= '0;
    end else begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule // pin_sync

// ===== core/flag_bank.sv
// Purpose: sticky status flags, set by hardware, cleared by writing zero
// Assumes: set and clear come from the system clock domain
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module flag_bank #(
  parameter int WIDTH = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] flags
);
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule // flag_bank

// ===== core/sd_emmc_host_ctrl_events.sv
// Purpose: control, event and interrupt registers of the SD/eMMC host
// Assumes: engine strobes are one-cycle pulses on SYS_CLK
// Notes: pads and card clock are synchronised before use
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "sd_host_defs.svh"
module sd_emmc_host_ctrl_events
  import sd_host_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire engine_events_type ENGINE_EVENTS,
  input wire logic CMD_TRIGGER,
  output engine_ctrl_type ENGINE_CTRL,
  output logic HOST_IRQ,
  output logic CARD_PRESENT,
  input wire logic DETECT_PIN,
  input wire logic PROTECT_PIN,
  input wire logic CARD_CLOCK_LINE,
  input wire logic TX_CMD_BIT,
  input wire logic TX_CMD_DRIVE,
  input wire logic [3:0] TX_DATA_LINES,
  input wire logic TX_DATA_DRIVE,
  input wire logic CARD_CMD_IN,
  output logic CARD_CMD_OUT,
  output logic CARD_CMD_OE_N,
  input wire logic [3:0] CARD_DATA_LINES_IN,
  output logic [3:0] CARD_DATA_LINES_OUT,
  output logic [3:0] CARD_DATA_LINES_OE_N,
  output logic RX_CMD,
  output logic [3:0] RX_DATA
);

  logic [31:0] main_ctrl;
  logic [13:0] event_en;
  logic [13:0] irq_en;
  logic global_en;
  logic [13:0] event_status;
  logic [13:0] irq_status;
  logic full_rst;
  logic iface_rst;
  logic hw_rst;
  logic ctrl_rst;
  logic flag_rst;
  logic [31:0] wmask;
  logic [31:0] wnew;
  logic wr_take;
  logic wr_main;
  logic wr_event;
  logic wr_irq;
  logic [31:0] next_readdata;
  logic [7:0] pad_raw;
  logic [7:0] pad_sync;
  logic detect_lvl;
  logic protect_lvl;
  logic clk_lvl;
  logic detect_prev;
  logic protect_prev;
  logic clk_prev;
  logic primed;
  logic [1:0] warm;
  logic detect_event;
  logic protect_event;
  logic launch;
  logic [3:0] lane_ok;
  logic [3:0] lanes;
  logic [13:0] src;
  logic [13:0] ev_set;
  logic [13:0] ev_clr;
  logic [13:0] irq_src;
  logic [13:0] irq_set;
  logic [13:0] irq_clr;
  logic pending;
  logic [1:0] wsel;

  assign full_rst = main_ctrl[`FULL_RST_BIT];
  assign iface_rst = main_ctrl[`IFACE_RST_BIT];
  assign hw_rst = SYS_RST | full_rst;
  assign ctrl_rst = SYS_RST | iface_rst;
  assign flag_rst = hw_rst | iface_rst;
  assign wsel = main_ctrl[`WSTART_MSB:`WSTART_LSB];

  // bus slave: one wait cycle, then a single ready cycle
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wr_take = AVS_WRITE & ~AVS_WAITREQUEST;
  assign wr_main = wr_take & (AVS_ADDRESS == `MAIN_CTRL_ADDR);
  assign wr_event = wr_take & (AVS_ADDRESS == `EVENT_CTRL_ADDR);
  assign wr_irq = wr_take & (AVS_ADDRESS == `IRQ_CTRL_ADDR);

  always_comb begin
    unique case (AVS_ADDRESS)
      `MAIN_CTRL_ADDR: next_readdata = main_ctrl;
      `EVENT_CTRL_ADDR: begin
        next_readdata = {detect_lvl, protect_lvl, event_status, 2'b00, event_en};
      end
      `IRQ_CTRL_ADDR: begin
        next_readdata = {HOST_IRQ, 1'b0, irq_status, global_en, 1'b0, irq_en};
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
      AVS_READDATA <= next_readdata;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // control register; the interface reset bit clears itself with the rest
  always_ff @(posedge SYS_CLK) begin
    if (ctrl_rst) begin
      main_ctrl <= `MAIN_CTRL_RESET;
    end else if (wr_main) begin
      main_ctrl <= ((main_ctrl & ~wmask) | (AVS_WRITEDATA & wmask)) & `MAIN_CTRL_MASK;
    end
  end

  assign wnew = AVS_WRITEDATA;

  always_ff @(posedge SYS_CLK) begin
    if (ctrl_rst) begin
      event_en <= `EVENT_EN_RESET;
    end else if (wr_event) begin
      event_en <= ((event_en & ~wmask[13:0]) | (wnew[13:0] & wmask[13:0])) & `EVENT_VALID;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (ctrl_rst) begin
      irq_en <= `IRQ_EN_RESET;
      global_en <= 1'b0;
    end else if (wr_irq) begin
      irq_en <= ((irq_en & ~wmask[13:0]) | (wnew[13:0] & wmask[13:0])) & `IRQ_VALID;
      if (wmask[`GLOBAL_EN_BIT]) begin
        global_en <= wnew[`GLOBAL_EN_BIT];
      end
    end
  end

  // pads and card clock arrive asynchronously
  assign pad_raw = {DETECT_PIN, PROTECT_PIN, CARD_CLOCK_LINE, CARD_CMD_IN, CARD_DATA_LINES_IN};

  pin_sync #(
    .WIDTH(8)
  ) pads (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .din(pad_raw),
    .dout(pad_sync)
  );

  assign detect_lvl = pad_sync[7];
  assign protect_lvl = pad_sync[6];
  assign clk_lvl = pad_sync[5];

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      detect_prev <= 1'b0;
      protect_prev <= 1'b0;
      clk_prev <= 1'b0;
      primed <= 1'b0;
      warm <= 2'b00;
    end else begin
      detect_prev <= detect_lvl;
      protect_prev <= protect_lvl;
      clk_prev <= clk_lvl;
      warm <= {warm[0], 1'b1};
      primed <= warm[1];
    end
  end

  // no pad event until the synchroniser holds real levels;
  // a pad idling high would otherwise flag a false change after reset
  assign detect_event = primed & (detect_lvl ^ detect_prev);
  assign protect_event = primed & (protect_lvl ^ protect_prev);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CARD_PRESENT <= 1'b0;
      RX_CMD <= 1'b0;
      RX_DATA <= 4'h0;
    end else begin
      CARD_PRESENT <= main_ctrl[`DETECT_POL_BIT] ? detect_lvl : ~detect_lvl;
      RX_CMD <= pad_sync[4];
      RX_DATA <= pad_sync[3:0];
    end
  end

  // event and interrupt sources, index = bit position minus 16
  assign src = {detect_event, protect_event, ENGINE_EVENTS.transfer_done_event,
                ENGINE_EVENTS.block_done, ENGINE_EVENTS.bad_crc_token_event,
                ENGINE_EVENTS.busy_timeout, ENGINE_EVENTS.read_done,
                ENGINE_EVENTS.single_read_done_event, ENGINE_EVENTS.read_crc_error,
                ENGINE_EVENTS.read_timeout, 1'b0, ENGINE_EVENTS.response_done,
                ENGINE_EVENTS.response_crc_error, ENGINE_EVENTS.response_timeout};
  // read end and single read ignore their enable bits, so they always flag
  assign ev_set = src & (event_en | `EVENT_ALWAYS_ON) & `EVENT_VALID;
  assign ev_clr = wr_event ? (wmask[`STATUS_MSB:`STATUS_LSB]
                  & ~wnew[`STATUS_MSB:`STATUS_LSB]) : 14'h0000;

  flag_bank #(
    .WIDTH(14)
  ) event_flags (
    .clk(SYS_CLK),
    .rst(flag_rst),
    .set(ev_set),
    .clr(ev_clr),
    .flags(event_status)
  );

  // direction error shares the response-end status slot
  always_comb begin
    irq_src = src;
    irq_src[`DIR_ERROR_IDX] = src[`DIR_ERROR_IDX] | ENGINE_EVENTS.response_direction_error;
  end
  assign irq_set = irq_src & irq_en & `IRQ_VALID;
  assign irq_clr = wr_irq ? (wmask[`STATUS_MSB:`STATUS_LSB]
                   & ~wnew[`STATUS_MSB:`STATUS_LSB]) : 14'h0000;

  flag_bank #(
    .WIDTH(14)
  ) irq_flags (
    .clk(SYS_CLK),
    .rst(flag_rst),
    .set(irq_set),
    .clr(irq_clr),
    .flags(irq_status)
  );

  assign pending = global_en & (|(irq_status & irq_en));

  always_ff @(posedge SYS_CLK) begin
    if (hw_rst) begin
      HOST_IRQ <= 1'b0;
    end else begin
      HOST_IRQ <= pending;
    end
  end

  // engine controls
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ENGINE_CTRL <= '0;
      ENGINE_CTRL.command_engine_reset <= 1'b1;
      ENGINE_CTRL.data_engine_reset <= 1'b1;
      ENGINE_CTRL.read_crc_check_enable <= 1'b1;
      ENGINE_CTRL.response_crc_check_enable <= 1'b1;
    end else begin
      ENGINE_CTRL.command_engine_reset <= full_rst | iface_rst | main_ctrl[`CMD_RST_BIT];
      ENGINE_CTRL.data_engine_reset <= full_rst | iface_rst | main_ctrl[`DATA_RST_BIT];
      ENGINE_CTRL.abort_transfer <= main_ctrl[`ABORT_BIT];
      ENGINE_CTRL.write_start <= wsel[1] ? wsel[0] : CMD_TRIGGER;
      ENGINE_CTRL.interface_power_on <= main_ctrl[`POWER_BIT];
      ENGINE_CTRL.read_crc_check_enable <= main_ctrl[`RD_CRC_BIT];
      ENGINE_CTRL.response_crc_check_enable <= main_ctrl[`RSP_CRC_BIT];
      ENGINE_CTRL.wide_bus_select <= main_ctrl[`WIDE_BUS_BIT];
    end
  end

  // line launch on the selected card clock edge
  assign launch = main_ctrl[`FAST_TIMING_BIT] ? (clk_lvl & ~clk_prev)
                  : (~clk_lvl & clk_prev);
  assign lane_ok = main_ctrl[`WIDE_BUS_BIT] ? 4'hF : 4'h1;
  assign lanes = {4{TX_DATA_DRIVE}} & lane_ok;

  // open drain only ever pulls low; the pad pull-up makes the one
  always_ff @(posedge SYS_CLK) begin
    if (hw_rst | ~main_ctrl[`POWER_BIT]) begin
      CARD_CMD_OUT <= 1'b0;
      CARD_CMD_OE_N <= 1'b1;
    end else if (launch) begin
      if (main_ctrl[`DRIVE_MODE_BIT]) begin
        CARD_CMD_OUT <= TX_CMD_BIT;
        CARD_CMD_OE_N <= ~TX_CMD_DRIVE;
      end else begin
        CARD_CMD_OUT <= 1'b0;
        CARD_CMD_OE_N <= ~(TX_CMD_DRIVE & ~TX_CMD_BIT);
      end
    end
  end

  // abort releases the data lanes without waiting for an edge
  always_ff @(posedge SYS_CLK) begin
    if (hw_rst | ~main_ctrl[`POWER_BIT] | main_ctrl[`ABORT_BIT]) begin
      CARD_DATA_LINES_OUT <= 4'h0;
      CARD_DATA_LINES_OE_N <= 4'hF;
    end else if (launch) begin
      if (main_ctrl[`DRIVE_MODE_BIT]) begin
        CARD_DATA_LINES_OUT <= TX_DATA_LINES & lane_ok;
        CARD_DATA_LINES_OE_N <= ~lanes;
      end else begin
        CARD_DATA_LINES_OUT <= 4'h0;
        CARD_DATA_LINES_OE_N <= ~(lanes & ~TX_DATA_LINES);
      end
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_full_reset_hold: assert property (
    full_rst |=> ENGINE_CTRL.command_engine_reset && ENGINE_CTRL.data_engine_reset
      && CARD_CMD_OE_N && (&CARD_DATA_LINES_OE_N) && !HOST_IRQ)
  else $error("full reset did not hold the hardware");

  a_iface_reset_clears: assert property (
    iface_rst |=> main_ctrl == `MAIN_CTRL_RESET && event_en == `EVENT_EN_RESET
      && irq_en == `IRQ_EN_RESET && !global_en && event_status == 14'h0000)
  else $error("interface reset left control state");

  a_cmd_reset_only: assert property (
    main_ctrl[`CMD_RST_BIT] && !full_rst && !iface_rst && !main_ctrl[`DATA_RST_BIT]
      |=> ENGINE_CTRL.command_engine_reset && !ENGINE_CTRL.data_engine_reset)
  else $error("command reset not isolated");

  a_data_reset_only: assert property (
    main_ctrl[`DATA_RST_BIT] && !full_rst && !iface_rst && !main_ctrl[`CMD_RST_BIT]
      |=> ENGINE_CTRL.data_engine_reset && !ENGINE_CTRL.command_engine_reset)
  else $error("data reset not isolated");

  a_abort_release: assert property (
    main_ctrl[`ABORT_BIT] |=> ENGINE_CTRL.abort_transfer && (&CARD_DATA_LINES_OE_N))
  else $error("abort did not stop the data lanes");

  a_write_start_sel: assert property (
    !iface_rst |=> ENGINE_CTRL.write_start
      == ($past(wsel) == `WSTART_HOLD ? 1'b0 : $past(wsel) == `WSTART_FORCE ? 1'b1
      : $past(CMD_TRIGGER)))
  else $error("write start source wrong");

  a_power_off_release: assert property (
    !main_ctrl[`POWER_BIT] ##1 !main_ctrl[`POWER_BIT] |-> CARD_CMD_OE_N
      && (&CARD_DATA_LINES_OE_N) && !ENGINE_CTRL.interface_power_on)
  else $error("lines driven with power off");

  a_detect_polarity: assert property (
    !$past(SYS_RST) |-> CARD_PRESENT == ($past(main_ctrl[`DETECT_POL_BIT])
      ? $past(detect_lvl) : !$past(detect_lvl)))
  else $error("card present polarity wrong");

  a_crc_enables: assert property (
    ENGINE_CTRL.read_crc_check_enable == $past(main_ctrl[`RD_CRC_BIT])
      && ENGINE_CTRL.response_crc_check_enable == $past(main_ctrl[`RSP_CRC_BIT]))
  else $error("crc enables do not follow control");

  a_narrow_lanes: assert property (
    launch && !main_ctrl[`WIDE_BUS_BIT] |=> &CARD_DATA_LINES_OE_N[3:1])
  else $error("upper lanes driven in narrow mode");

  a_launch_edge: assert property (
    !launch && !hw_rst && main_ctrl[`POWER_BIT] && !main_ctrl[`ABORT_BIT]
      |=> $stable(CARD_DATA_LINES_OE_N) && $stable(CARD_CMD_OE_N))
  else $error("lines changed off the launch edge");

  a_event_set_wins: assert property (
    ev_set != 14'h0000 && !flag_rst |=> (event_status & $past(ev_set)) == $past(ev_set))
  else $error("event flag not set");

  a_single_read_flag: assert property (
    ENGINE_EVENTS.single_read_done_event && !flag_rst |=> event_status[`SINGLE_READ_IDX])
  else $error("single read flag missing");

  a_irq_enabled_only: assert property (
    !wr_irq |=> (irq_status & ~$past(irq_status) & ~$past(irq_en)) == 14'h0000)
  else $error("disabled source raised interrupt status");

  a_dir_error_irq: assert property (
    ENGINE_EVENTS.response_direction_error && irq_en[`DIR_ERROR_IDX] && !flag_rst
      |=> irq_status[`DIR_ERROR_IDX])
  else $error("direction error interrupt missing");

  a_irq_summary: assert property (
    !hw_rst |=> HOST_IRQ == ($past(global_en) && |($past(irq_status) & $past(irq_en))))
  else $error("host interrupt summary wrong");

endmodule // sd_emmc_host_ctrl_events

// ===== verif/sd_card_model.sv
// Purpose: card side of the link, clock source and pulled-up lines
// Assumes: the card stays silent, so every released line floats high
// Notes: the card clock stands low between bursts
`timescale 1ns/1ps
module sd_card_model (
  input wire logic go,
  input wire logic [3:0] periods,
  output logic card_clk,
  input wire logic cmd_out,
  input wire logic cmd_oe_n,
  input wire logic [3:0] data_out,
  input wire logic [3:0] data_oe_n,
  output logic cmd_wire,
  output logic [3:0] data_wire
);
  initial card_clk = 1'b0;
  // 320 ns period, only inside a burst
  always @(posedge go) begin
    repeat (periods) begin
      #160 card_clk = 1'b1;
      #160 card_clk = 1'b0;
    end
  end
  // released lines show the pull-up, not the last driven value
  assign cmd_wire = cmd_oe_n ? 1'b1 : cmd_out;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data_wire[i] = data_oe_n[i] ? 1'b1 : data_out[i];
    end
  end
endmodule // sd_card_model

// ===== verif/sd_emmc_host_ctrl_events_tb.sv
// Purpose: register, event, interrupt and line checks of the host block
// Assumes: one wait cycle per bus request, pads settle within eight clocks
// Notes: the card never drives, so read-back lines show the host's own value, or the pull-up where released
`timescale 1ns/1ps
`include "sd_host_defs.svh"
module sd_emmc_host_ctrl_events_tb import sd_host_pkg::*;;
  logic SYS_CLK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CMD_TRIGGER, HOST_IRQ;
  logic CARD_PRESENT, DETECT_PIN, PROTECT_PIN, CARD_CLOCK_LINE, TX_CMD_BIT, TX_CMD_DRIVE;
  logic TX_DATA_DRIVE, CARD_CMD_IN, CARD_CMD_OUT, CARD_CMD_OE_N, RX_CMD, go;
  logic [31:0] AVS_ADDRESS, AVS_WRITEDATA, AVS_READDATA, rdata;
  logic [3:0] AVS_BYTEENABLE, TX_DATA_LINES, CARD_DATA_LINES_IN, CARD_DATA_LINES_OUT;
  logic [3:0] CARD_DATA_LINES_OE_N, RX_DATA, periods;
  engine_events_type ENGINE_EVENTS;
  engine_ctrl_type ENGINE_CTRL;
  int failures = 0;
  int comparisons = 0;
  localparam logic [31:0] ma = `MAIN_CTRL_ADDR;
  localparam logic [31:0] ea = `EVENT_CTRL_ADDR;
  localparam logic [31:0] ia = `IRQ_CTRL_ADDR;

  sd_emmc_host_ctrl_events sd_emmc_host_ctrl_events_inst (.SYS_CLK, .SYS_RST, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .ENGINE_EVENTS, .CMD_TRIGGER, .ENGINE_CTRL, .HOST_IRQ, .CARD_PRESENT, .DETECT_PIN,
    .PROTECT_PIN, .CARD_CLOCK_LINE, .TX_CMD_BIT, .TX_CMD_DRIVE, .TX_DATA_LINES,
    .TX_DATA_DRIVE, .CARD_CMD_IN, .CARD_CMD_OUT, .CARD_CMD_OE_N, .CARD_DATA_LINES_IN,
    .CARD_DATA_LINES_OUT, .CARD_DATA_LINES_OE_N, .RX_CMD, .RX_DATA);

  sd_card_model sd_card_model_inst (.go, .periods, .card_clk(CARD_CLOCK_LINE),
    .cmd_out(CARD_CMD_OUT), .cmd_oe_n(CARD_CMD_OE_N), .data_out(CARD_DATA_LINES_OUT),
    .data_oe_n(CARD_DATA_LINES_OE_N), .cmd_wire(CARD_CMD_IN), .data_wire(CARD_DATA_LINES_IN));

  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      failures++;
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  // request held until waitrequest is seen low; one idle edge keeps strobes apart
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    rdata = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      $display("mismatch at %0t: bus answer never came", $time);
      failures++;
      wrap_up();
    end
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdata, exp, what);
  endtask

  task automatic ctl(input logic [7:0] exp, input string what);
    ticks(2);
    chk({24'h00_0000, ENGINE_CTRL}, {24'h00_0000, exp}, what);
  endtask

  task automatic pulse(input logic [11:0] e);
    ENGINE_EVENTS <= e;
    ticks(1);
    ENGINE_EVENTS <= 12'h000;
    ticks(2);
  endtask

  task automatic burst(input int n);
    periods <= 4'(n);
    go <= 1'b1;
    ticks(1);
    go <= 1'b0;
    ticks(8 * n + 8);
  endtask

  task automatic lines(input logic [31:0] exp, input string what);
    chk({24'h00_0000, CARD_DATA_LINES_OE_N, CARD_DATA_LINES_OUT}, exp, what);
  endtask

  initial begin
    int bitpos;
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, CMD_TRIGGER, DETECT_PIN} = '0;
    {PROTECT_PIN, TX_CMD_BIT, TX_CMD_DRIVE, TX_DATA_LINES, TX_DATA_DRIVE, go, periods} = '0;
    ENGINE_EVENTS = 12'h000;
    AVS_BYTEENABLE = 4'hF;
    SYS_RST = 1'b1;
    ticks(6);
    SYS_RST <= 1'b0;
    ticks(1);
    rd(ma, 32'h0000_0018, "main reset value");
    rd(ea, 32'h0000_1A37, "event enables reset value");
    rd(ia, 32'h0000_0000, "irq reset value");
    rd(32'h5003_000C, 32'h0000_0000, "unmapped read");
    ctl(8'b0000_0110, "crc checks on after reset");
    $display("test reset values done");
    wr(ma, 32'h0000_2018);
    ctl(8'b1000_0110, "command engine reset only");
    wr(ma, 32'h0000_1018);
    ctl(8'b0100_0110, "data engine reset only");
    wr(ma, 32'h0000_3B84);
    ctl(8'b1111_1001, "control fields");
    rd(ma, 32'h0000_3B84, "main readback");
    CMD_TRIGGER <= 1'b1;
    wr(ma, 32'h0000_0200);
    ctl(8'b0000_0000, "write start withheld");
    wr(ma, 32'h0000_0018);
    ctl(8'b0001_0110, "write start by trigger");
    CMD_TRIGGER <= 1'b0;
    ctl(8'b0000_0110, "trigger dropped");
    wr(ma, 32'h0000_8018);
    ctl(8'b1100_0110, "full reset holds engines");
    pulse(12'h800);
    rd(ea, 32'h0000_1A37, "full reset holds flags");
    wr(ma, 32'h0000_0018);
    $display("test control bits done");
    wr(ea, 32'h0000_3FF7);
    for (int i = 1; i < 12; i++) begin
      bitpos = (i < 4) ? 15 + i : 16 + i;
      pulse(12'h001 << i);
      rd(ea, (32'h1 << bitpos) | 32'h0000_3FF7, "own event flag");
      wr(ea, 32'h0000_3FF7);
    end
    rd(ea, 32'h0000_3FF7, "flags cleared by zero");
    wr(ea, 32'h0000_0000);
    pulse(12'hFFF);
    rd(ea, 32'h00C0_0000, "only read end flags unmasked");
    wr(ea, 32'h0000_1A37);
    DETECT_PIN <= 1'b1;
    ticks(8);
    rd(ea, 32'h8000_1A37, "detect change masked");
    chk({31'h0, CARD_PRESENT}, 32'h0, "active low detect");
    wr(ma, 32'h0000_0038);
    ticks(3);
    chk({31'h0, CARD_PRESENT}, 32'h1, "active high detect");
    wr(ea, 32'h0000_3A37);
    DETECT_PIN <= 1'b0;
    PROTECT_PIN <= 1'b1;
    ticks(8);
    rd(ea, 32'h7000_3A37, "pad levels and events");
    $display("test events done");
    wr(ia, 32'h0000_0400);
    pulse(12'h500);
    rd(ia, 32'h0400_0400, "only enabled irq flag");
    chk({31'h0, HOST_IRQ}, 32'h0, "global enable off");
    wr(ia, 32'h0400_8404);
    ticks(2);
    chk({31'h0, HOST_IRQ}, 32'h1, "host irq raised");
    pulse(12'h001);
    rd(ia, 32'h8404_8404, "direction error irq");
    wr(ia, 32'h0000_8404);
    ticks(2);
    chk({31'h0, HOST_IRQ}, 32'h0, "host irq cleared");
    rd(ia, 32'h0000_8404, "irq flags cleared");
    wr(ma, 32'h0000_4038);
    ticks(2);
    rd(ma, 32'h0000_0018, "interface reset main");
    rd(ea, 32'h4000_1A37, "interface reset events");
    rd(ia, 32'h0000_0000, "interface reset irq");
    $display("test interrupts done");
    TX_DATA_DRIVE <= 1'b1;
    TX_CMD_DRIVE <= 1'b1;
    TX_DATA_LINES <= 4'h5;
    wr(ma, 32'h0000_0099);
    burst(2);
    chk({25'h0, CARD_DATA_LINES_OE_N, CARD_DATA_LINES_OUT[0], CARD_CMD_OE_N, CARD_CMD_OUT},
      32'h0000_0074, "one lane");
    wr(ma, 32'h0000_009D);
    burst(2);
    lines(32'h0000_0005, "four lanes");
    chk({27'h0, RX_CMD, RX_DATA}, 32'h0000_0005, "lines read back");
    TX_DATA_LINES <= 4'hA;
    periods <= 4'd1;
    go <= 1'b1;
    ticks(8);
    lines(32'h0000_0005, "no launch on rising edge");
    go <= 1'b0;
    ticks(8);
    lines(32'h0000_000A, "launch on falling edge");
    wr(ma, 32'h0000_089D);
    ticks(2);
    chk({28'h0, CARD_DATA_LINES_OE_N}, 32'h0000_000F, "abort releases lines");
    wr(ma, 32'h0000_009D);
    burst(1);
    wr(ma, 32'h0000_001D);
    ticks(2);
    chk({28'h0, CARD_DATA_LINES_OE_N}, 32'h0000_000F, "power off releases");
    TX_CMD_BIT <= 1'b1;
    wr(ma, 32'h0000_009E);
    periods <= 4'd1;
    go <= 1'b1;
    ticks(8);
    lines(32'h0000_00A0, "open drain, rising edge launch");
    chk({30'h0, CARD_CMD_OE_N, CARD_CMD_OUT}, 32'h0000_0002, "open drain command released");
    go <= 1'b0;
    ticks(8);
    $display("test lines done");
    wrap_up();
  end
endmodule // sd_emmc_host_ctrl_events_tb
